// file: aaf_regs.svh
`ifndef AAF_REGS_SVH
`define AAF_REGS_SVH
// ==========================================================
// register map (apb byte addresses)
`define AAF_OFF_CTRL      12'h000
`define AAF_OFF_STATUS    12'h004
`define AAF_OFF_DATA      12'h008
`define AAF_OFF_COUNT     12'h00c
// ==========================================================
// control fields
`define AAF_CTRL_MODE_LSB 0
`define AAF_CTRL_MODE_MSB 1
`define AAF_CTRL_RATIO_LSB 4
`define AAF_CTRL_RATIO_MSB 6
`define AAF_CTRL_RATE_LSB 8
`define AAF_CTRL_RATE_MSB 12
`define AAF_CTRL_EN_BIT   16
`define AAF_CTRL_RESET    32'h0000_0000
// ==========================================================
// timing and rates
`define AAF_ADC_RATE_MSPS 100
`define AAF_ANALOG_FC_MHZ 10
`define AAF_FIFO_DEPTH    16
`define AAF_SAMPLE_W      14
`define AAF_OUT_W         16
`endif

// file: aaf_pkg.sv
`default_nettype none
package aaf_pkg;
  // filter path selection
  typedef enum logic [1:0] {
    AAF_MODE_BYPASS = 2'b00, // unfiltered_bypass_mode
    AAF_MODE_ABES   = 2'b01, // analog bessel only
    AAF_MODE_BESIIR = 2'b10, // analog + digital bessel
    AAF_MODE_BUTIIR = 2'b11  // analog + digital butterworth
  } aaf_mode_t;
  // cutoff ratio relative to output rate
  typedef enum logic [2:0] {
    AAF_R4   = 3'b000,
    AAF_R10  = 3'b001,
    AAF_R20  = 3'b010,
    AAF_R40  = 3'b011,
    AAF_R100 = 3'b100
  } aaf_ratio_t;
endpackage : aaf_pkg
`default_nettype wire

// file: aaf_fifo.sv
`default_nettype none
module aaf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth");
  end
  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];  // word store
  logic [AW:0]      wr_ptr;       // write pointer, extra wrap bit
  logic [AW:0]      rd_ptr;       // read pointer
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign do_wr = i_ce && i_in_valid && !full;
  assign do_rd = i_ce && i_out_ready && !empty;
  // read data is the registered head word; a write into the
  // slot that becomes the head is forwarded, else it is stale
  logic [AW-1:0]    rd_nxt;       // head index after this edge
  assign rd_nxt = rd_ptr[AW-1:0] + AW'(do_rd);
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (do_wr && wr_ptr[AW-1:0] == rd_nxt) begin
        o_out_data <= i_in_data;
      end else begin
        o_out_data <= mem[rd_nxt];
      end
    end
  end
  // write port
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
  // pointer update
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : aaf_fifo
`default_nettype wire

// file: aaf_iir.sv
`default_nettype none
// one first-order leaky stage per section; cascaded sections make
// the higher order response. shift sets the pole position.
module aaf_iir #(
  parameter int IN_W  = 14,
  parameter int ACC_W = 32,
  parameter int STAGES = 4
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_ce,
  input  wire logic                    i_clear,
  input  wire logic [4:0]              i_shift,
  input  wire logic                    i_shape,
  input  wire logic signed [IN_W-1:0]  i_sample,
  output logic signed [ACC_W-1:0]      o_result
);
  initial begin
    if (STAGES < 1 || ACC_W < IN_W + 17) $error("iir size");
  end
  // ==========================================================
  // cascade state
  logic signed [ACC_W-1:0] acc [STAGES];
  logic [4:0]              sh_eff;  // shape off trims pole by one, same in all stages
  assign sh_eff = i_shape ? i_shift : i_shift - 5'd1;
  assign o_result = acc[STAGES-1];
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int k = 0; k < STAGES; k++) begin
        acc[k] <= '0;
      end
    end else if (i_ce) begin
      if (i_clear) begin
        // identical reset per channel keeps phase matched
        for (int k = 0; k < STAGES; k++) begin
          acc[k] <= '0;
        end
      end else begin
        acc[0] <= acc[0] + ((($signed(i_sample) <<< 16)
                  - acc[0]) >>> sh_eff);
        for (int k = 1; k < STAGES; k++) begin
          acc[k] <= acc[k] + ((acc[k-1] - acc[k]) >>> sh_eff);
        end
      end
    end
  end
endmodule : aaf_iir
`default_nettype wire

// file: aaf_top.sv
// Summary of operation
// - input always at fixed converter rate
// - filter at full rate, then decimate
// - cutoff tracks selected output rate
// - bypass mode skips all filtering
// - bypass mode gives no enhanced resolution
// - analog-only: fixed cutoff, no enhancement
// - bessel iir enables analog plus digital
// - butterworth iir enables analog plus digital
// - iir: 15 bit <=25MS/s, 16 bit <=10MS/s
// - ratios 4,10,20,40; 100 bessel only
// - same settings give identical processing
// - analog stage cutoff independent of rate
// - analog bessel allowed at every rate
//
// Design decisions made here: the register offsets and register access over APB.
`include "aaf_regs.svh"
`default_nettype none
module aaf_top #(
  parameter int SAMPLE_W = `AAF_SAMPLE_W,
  parameter int OUT_W    = `AAF_OUT_W,
  parameter int DEPTH    = `AAF_FIFO_DEPTH
) (
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_ce,
  // converter stream, same clock, one word per valid cycle
  input  wire logic [SAMPLE_W-1:0] i_adc_data,
  input  wire logic                i_adc_valid,
  // decimated output stream
  output logic      [OUT_W-1:0]    o_out_data,
  output logic      [4:0]          o_out_bits,
  output logic                     o_out_valid,
  input  wire logic                i_out_ready,
  // analog front selects
  output logic                     o_analog_bessel_en,
  output logic                     o_analog_butter_en,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr
);
  import aaf_pkg::*;
  initial begin
    if (SAMPLE_W < 8 || SAMPLE_W > 16 || OUT_W != 16) begin
      $error("aaf_top width parameters unsupported");
    end
  end
  // ==========================================================
  // rate table: index 0..29, output rate = 100 MS/s / divider
  // 100M,50M,25M,12.5M,10M,5M,2.5M,2M,1.25M,1M,500k,400k,250k,
  // 200k,125k,100k,50k,40k,25k,20k,12.5k,10k,5k,4k,2.5k,2k,
  // 1.25k,1k,500,400
  localparam int NRATE = 30;
  function automatic logic [19:0] rate_div(input logic [4:0] r);
    logic [19:0] d;
    d = 20'd1;
    case (r)
      5'd0:  d = 20'd1;
      5'd1:  d = 20'd2;
      5'd2:  d = 20'd4;
      5'd3:  d = 20'd8;
      5'd4:  d = 20'd10;
      5'd5:  d = 20'd20;
      5'd6:  d = 20'd40;
      5'd7:  d = 20'd50;
      5'd8:  d = 20'd80;
      5'd9:  d = 20'd100;
      5'd10: d = 20'd200;
      5'd11: d = 20'd250;
      5'd12: d = 20'd400;
      5'd13: d = 20'd500;
      5'd14: d = 20'd800;
      5'd15: d = 20'd1000;
      5'd16: d = 20'd2000;
      5'd17: d = 20'd2500;
      5'd18: d = 20'd4000;
      5'd19: d = 20'd5000;
      5'd20: d = 20'd8000;
      5'd21: d = 20'd10000;
      5'd22: d = 20'd20000;
      5'd23: d = 20'd25000;
      5'd24: d = 20'd40000;
      5'd25: d = 20'd50000;
      5'd26: d = 20'd80000;
      5'd27: d = 20'd100000;
      5'd28: d = 20'd200000;
      5'd29: d = 20'd250000;
      default: d = 20'd1;
    endcase
    return d;
  endfunction : rate_div
  // permitted ratio index per mode and rate (table gaps)
  function automatic logic cfg_ok(input aaf_mode_t m,
                                  input aaf_ratio_t q,
                                  input logic [4:0] r);
    logic ok;
    ok = (r < 5'(NRATE));
    if (m == AAF_MODE_BESIIR || m == AAF_MODE_BUTIIR) begin
      if (q > AAF_R100) ok = 1'b0;
      if (q == AAF_R100 && m != AAF_MODE_BESIIR) ok = 1'b0;
      if (q == AAF_R4 && r <= 5'd2) ok = 1'b0;
      if (q == AAF_R10 && r == 5'd0) ok = 1'b0;
      // last columns empty at the slowest rates
      if (q == AAF_R100 && r >= 5'd23) ok = 1'b0;
      if (q == AAF_R40 && r >= 5'd26) ok = 1'b0;
      if (q == AAF_R20 && r >= 5'd28) ok = 1'b0;
      if (q == AAF_R10 && r >= 5'd29) ok = 1'b0;
    end
    return ok; // analog bessel and bypass at any rate
  endfunction : cfg_ok
  // log2 of ratio times divider approximates pole shift
  function automatic logic [4:0] pole_shift(input aaf_ratio_t q,
                                            input logic [19:0] d);
    logic [4:0] s;
    logic [4:0] b;
    s = 5'd0;
    case (q)
      AAF_R4:   b = 5'd1;
      AAF_R10:  b = 5'd2;
      AAF_R20:  b = 5'd3;
      AAF_R40:  b = 5'd4;
      AAF_R100: b = 5'd6;
      default:  b = 5'd1;
    endcase
    for (int i = 0; i < 20; i++) begin
      if (d[i]) s = 5'(i);
    end
    return (5'(s + b) > 5'd20) ? 5'd20 : 5'(s + b);
  endfunction : pole_shift
  // ==========================================================
  // control registers
  aaf_mode_t   mode;       // active filter path
  aaf_ratio_t  ratio;      // active cutoff ratio
  logic [4:0]  rate_sel;   // active output rate index
  logic        run;        // stream enable
  logic        cfg_err;    // last write refused
  logic [4:0]  shift;      // derived pole position
  logic [19:0] div;        // derived decimation factor
  logic        recfg;      // one-cycle restart of filter path
  logic        apb_wr;
  logic        apb_rd;
  aaf_mode_t   wr_mode;
  aaf_ratio_t  wr_ratio;
  logic [4:0]  wr_rate;
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;
  assign wr_mode  = aaf_mode_t'(pwdata[`AAF_CTRL_MODE_MSB:
                                       `AAF_CTRL_MODE_LSB]);
  assign wr_ratio = aaf_ratio_t'(pwdata[`AAF_CTRL_RATIO_MSB:
                                        `AAF_CTRL_RATIO_LSB]);
  assign wr_rate  = pwdata[`AAF_CTRL_RATE_MSB:`AAF_CTRL_RATE_LSB];
  // control write; a bad combination keeps old settings
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode     <= AAF_MODE_BYPASS;
      ratio    <= AAF_R4;   // matches the all-zero ctrl reset word
      rate_sel <= 5'd0;
      run      <= 1'b0;
      cfg_err  <= 1'b0;
      recfg    <= 1'b0;
    end else if (i_ce) begin
      recfg <= 1'b0;
      if (apb_wr && paddr == `AAF_OFF_CTRL) begin
        if (cfg_ok(wr_mode, wr_ratio, wr_rate)) begin
          mode     <= wr_mode;
          ratio    <= wr_ratio;
          rate_sel <= wr_rate;
          run      <= pwdata[`AAF_CTRL_EN_BIT];
          cfg_err  <= 1'b0;
          recfg    <= 1'b1;
        end else begin
          cfg_err <= 1'b1;
        end
      end
    end
  end
  // cutoff and factor follow any rate change automatically
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift <= 5'd2;
      div   <= 20'd1;
    end else if (i_ce) begin
      shift <= pole_shift(ratio, rate_div(rate_sel));
      div   <= rate_div(rate_sel);
    end
  end
  // analog fronts fixed, never depend on rate
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_analog_bessel_en <= 1'b0;
      o_analog_butter_en <= 1'b0;
    end else if (i_ce) begin
      o_analog_bessel_en <= (mode == AAF_MODE_ABES) ||
                            (mode == AAF_MODE_BESIIR);
      o_analog_butter_en <= (mode == AAF_MODE_BUTIIR);
    end
  end
  // ==========================================================
  // full-rate digital filter, always ahead of decimation
  logic signed [31:0] iir_y;
  logic               iir_on;
  assign iir_on = (mode == AAF_MODE_BESIIR) || (mode == AAF_MODE_BUTIIR);
  aaf_iir #(
    .IN_W   (SAMPLE_W),
    .ACC_W  (32),
    .STAGES (4)
  ) u_iir (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    // the clear only acts on an enabled edge, so recfg opens it
    .i_ce      (i_ce && (i_adc_valid || recfg)),
    .i_clear   (recfg || !iir_on),
    .i_shift   (shift),
    .i_shape   (mode == AAF_MODE_BESIIR),
    .i_sample  ($signed(i_adc_data)),
    .o_result  (iir_y)
  );
  // ==========================================================
  // decimator: one output per div input samples
  logic [19:0]      dec_cnt;   // samples since last output
  logic [OUT_W-1:0] dec_word;  // word into fifo
  logic [4:0]       dec_bits;  // effective resolution
  logic             dec_vld;
  logic             fifo_rdy;
  logic [4:0]       res_bits;
  logic [OUT_W-1:0] path_word;
  // resolution gain only with iir at low rates
  always_comb begin
    res_bits = 5'(SAMPLE_W);
    if (iir_on && div >= 20'd10) begin
      res_bits = 5'd16;
    end else if (iir_on && div >= 20'd4) begin
      res_bits = 5'd15;
    end                          // bypass/analog stay native
  end
  // path select: raw samples in bypass or analog-only
  always_comb begin
    if (iir_on) begin
      path_word = iir_y[16+SAMPLE_W-1 -: OUT_W];
    end else begin
      path_word = {i_adc_data, {(OUT_W-SAMPLE_W){1'b0}}};
    end
  end
  // drop decimated word only if the fifo cannot take it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dec_cnt  <= 20'd0;
      dec_vld  <= 1'b0;
      dec_word <= '0;
      dec_bits <= 5'd0;
    end else if (i_ce) begin
      if (dec_vld && fifo_rdy) begin
        dec_vld <= 1'b0;
      end
      if (recfg || !run) begin
        dec_cnt <= 20'd0;
      end else if (i_adc_valid) begin
        if (dec_cnt >= div - 20'd1) begin
          dec_cnt  <= 20'd0;
          dec_vld  <= 1'b1;
          // truncate to the enhanced width, low bits zero
          dec_word <= path_word & ~(16'hffff >> res_bits);
          dec_bits <= res_bits;
        end else begin
          dec_cnt <= dec_cnt + 20'd1;
        end
      end
    end
  end
  // ==========================================================
  // output fifo, carries data and resolution tag
  logic             f_vld;
  logic [OUT_W+4:0] f_data;
  logic             take;
  aaf_fifo #(
    .WIDTH (OUT_W + 5),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_ce        (i_ce),
    .i_in_valid  (dec_vld),
    .o_in_ready  (fifo_rdy),
    .i_in_data   ({dec_bits, dec_word}),
    .o_out_valid (f_vld),
    .i_out_ready (take),
    .o_out_data  (f_data)
  );
  // output skid register; refills when empty or consumed
  assign take = f_vld && (!o_out_valid || i_out_ready);
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
      o_out_bits  <= 5'd0;
    end else if (i_ce) begin
      if (take) begin
        o_out_valid <= 1'b1;
        o_out_data  <= f_data[OUT_W-1:0];
        o_out_bits  <= f_data[OUT_W+4:OUT_W];
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // apb read path, registered, answers in access phase
  logic [31:0] status;
  assign status = {25'h0, f_vld, !fifo_rdy, dec_bits[4:0]} |
                  {31'h0, cfg_err} << 7;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (i_ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(paddr == `AAF_OFF_CTRL || paddr == `AAF_OFF_STATUS ||
                   paddr == `AAF_OFF_DATA || paddr == `AAF_OFF_COUNT);
      if (apb_rd) begin
        case (paddr)
          `AAF_OFF_CTRL:   prdata <= {15'h0, run, 3'h0, rate_sel,
                                      1'b0, ratio, 2'h0, mode};
          `AAF_OFF_STATUS: prdata <= status;
          `AAF_OFF_DATA:   prdata <= {16'h0, o_out_data};
          `AAF_OFF_COUNT:  prdata <= {12'h0, div};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : aaf_top
`default_nettype wire

// file: aaf_adc_model.sv
`default_nettype none
// ======================================================
// converter model: one strobe every GAP cycles while i_run is high
module aaf_adc_model #(
  parameter int GAP = 2  // cycles per sample, fixed rate
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_run,
  output logic      [13:0] o_data,
  output logic             o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;  // phase inside one sample period
  // the strobe spacing never follows the output rate choice
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt     <= 0;
      o_valid <= 1'b0;
      o_data  <= '0;
    end else if (i_run && cnt == GAP - 1) begin
      cnt     <= 0;
      o_valid <= 1'b1;
      o_data  <= 14'($urandom);
    end else begin
      // off-strobe the bus toggles so stale data never looks valid
      cnt     <= i_run ? cnt + 1 : 0;
      o_valid <= 1'b0;
      o_data  <= ~o_data;
    end
  end
endmodule : aaf_adc_model
`default_nettype wire

// file: aaf_top_props.sv
`default_nettype none
// ======================================================
// port checker for the filter top
module aaf_top_props #(
  parameter int OUT_W = 16
) (
  input wire logic             i_clk,
  input wire logic             i_sys_rst,
  input wire logic [OUT_W-1:0] o_out_data,
  input wire logic [4:0]       o_out_bits,
  input wire logic             o_out_valid,
  input wire logic             i_out_ready,
  input wire logic             o_analog_bessel_en,
  input wire logic             o_analog_butter_en,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic             pslverr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic             wr_ctrl;   // control write completes
  logic             rate_ok;   // rate index in range
  logic             iir_ok;    // ratio 20 or 40 at rate index 22 or below, always legal
  logic [OUT_W-1:0] low_mask;  // bits unused at this resolution
  assign wr_ctrl  = psel && penable && pready && pwrite && paddr == 12'h000;
  assign rate_ok  = pwdata[12:8] <= 5'd29;
  assign iir_ok   = pwdata[6:5] == 2'b01 && pwdata[12:8] <= 5'd22;
  assign low_mask = (o_out_bits == 5'd14) ? OUT_W'(3) :
                    (o_out_bits == 5'd15) ? OUT_W'(1) : '0;
  // ======================================================
  // bus handshake
  AST_PREADY_ACCESS:
    assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  AST_PREADY_PULSE:
    assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  // ======================================================
  // front selects follow the mode written
  AST_FRONT_EXCL:
    assert property (!(o_analog_bessel_en && o_analog_butter_en))
    else $error("both analog fronts on");
  AST_BYPASS_FRONT:
    assert property (wr_ctrl && pwdata[1:0] == 2'd0 && rate_ok |->
      ##[1:4] !o_analog_bessel_en && !o_analog_butter_en)
    else $error("bypass left a front on");
  AST_ABES_FRONT:
    assert property (wr_ctrl && pwdata[1:0] == 2'd1 && rate_ok |->
      ##[1:4] o_analog_bessel_en && !o_analog_butter_en)
    else $error("analog bessel front missing");
  AST_BES_FRONT:
    assert property (wr_ctrl && pwdata[1:0] == 2'd2 && iir_ok |->
      ##[1:4] o_analog_bessel_en && !o_analog_butter_en)
    else $error("bessel iir front missing");
  AST_BUT_FRONT:
    assert property (wr_ctrl && pwdata[1:0] == 2'd3 && iir_ok |->
      ##[1:4] o_analog_butter_en && !o_analog_bessel_en)
    else $error("butterworth iir front missing");
  // ======================================================
  // output words
  AST_BITS_SET:
    assert property (o_out_valid |->
      o_out_bits inside {5'd14, 5'd15, 5'd16})
    else $error("odd resolution");
  AST_LOW_ZERO:
    assert property (o_out_valid |-> (o_out_data & low_mask) == '0)
    else $error("unused low bits set");
  AST_OUT_STANDS:
    assert property (o_out_valid && !i_out_ready |=> o_out_valid &&
      $stable(o_out_data) && $stable(o_out_bits))
    else $error("word dropped before taken");
  cover property (wr_ctrl && pwdata[1:0] == 2'd2);
  cover property (o_out_valid && o_out_bits == 5'd16);
  cover property (pready && pslverr);
endmodule : aaf_top_props
bind aaf_top aaf_top_props #(.OUT_W(OUT_W)) aaf_top_props_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_out_data(o_out_data),
  .o_out_bits(o_out_bits), .o_out_valid(o_out_valid),
  .i_out_ready(i_out_ready), .o_analog_bessel_en(o_analog_bessel_en),
  .o_analog_butter_en(o_analog_butter_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: aaf_top_bench.sv
`default_nettype none
// ======================================================
// self-checking bench for the filter top
module aaf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import aaf_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; logic e;} aaf_rd_t;
  logic        i_clk, i_sys_rst, i_out_ready, run, exact, hold, ov;
  logic        psel, penable, pwrite, pready, pslverr, valid, bess, butt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, last, exp_bits;
  logic [13:0] adc;
  logic [15:0] o_out_data;
  logic [4:0]  o_out_bits;
  int          miscompares, n_compared, cyc, q;
  aaf_rd_t     rd_q[$];   // expected read answers, oldest first
  logic [15:0] wd_q[$];   // expected words in exact mode
  // mode, ratio, rate index, bits, fronts, decimation per row
  int t_m[6] = '{0, 0, 1, 2, 3, 2};
  int t_r[6] = '{2, 2, 2, 2, 3, 4};
  int t_s[6] = '{0, 4, 4, 2, 4, 4};
  int t_b[6] = '{14, 14, 14, 15, 16, 16};
  int t_f[6] = '{0, 0, 2, 2, 1, 2};
  int t_d[6] = '{1, 10, 10, 4, 10, 10};
  // illegal selections: mode, ratio, rate index
  int x_m[5] = '{3, 2, 2, 3, 2};
  int x_r[5] = '{4, 0, 1, 0, 0};
  int x_s[5] = '{4, 0, 0, 1, 2};
  aaf_top aaf_top_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
    .i_adc_data(adc), .i_adc_valid(valid), .o_out_data(o_out_data),
    .o_out_bits(o_out_bits), .o_out_valid(ov), .i_out_ready(i_out_ready),
    .o_analog_bessel_en(bess), .o_analog_butter_en(butt), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aaf_adc_model aaf_adc_model_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_run(run), .o_data(adc), .o_valid(valid));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ======================================================
  // helpers
  function automatic logic [31:0] cw(int m, int r, int s);
    return 32'(m) | (32'(r) << 4) | (32'(s) << 8) | 32'h1_0000;
  endfunction : cw
  task automatic check(logic [31:0] got, logic [31:0] exp, string w);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : check
  // one apb transfer; released at the edge where ready is seen
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(logic [11:0] a, logic [31:0] v, logic [31:0] m,
                    logic e);
    rd_q.push_back('{v, m, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // stop the stream, let the pipe run dry, then reprogram
  task automatic cfg(int m, int r, int s, int b, logic ex);
    run <= 1'b0;
    q = 0;
    while (q < 12) begin
      @(negedge i_clk);
      q = ov ? 0 : q + 1;
    end
    check(32'(wd_q.size()), 0, "words lost");
    exact <= ex;
    last = cw(m, r, s);
    apb(1'b1, 12'h000, last);
    exp_bits = 32'(b);
    run <= 1'b1;
  endtask : cfg
  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ======================================================
  // monitors: notes are taken off the queues as results show
  always @(posedge i_clk) begin
    if (exact && valid)
      wd_q.push_back({adc, 2'b00});
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      check(prdata & rd_q[0].m, rd_q[0].v, "read");
      check(32'(pslverr), 32'(rd_q[0].e), "slverr");
      void'(rd_q.pop_front());
    end
    if (ov && i_out_ready) begin
      check(32'(o_out_bits), exp_bits, "bits");
      if (exact && wd_q.size() > 0)
        check(32'(o_out_data), 32'(wd_q.pop_front()), "word");
    end
  end
  // consumer stalls at random unless held off
  always @(posedge i_clk)
    i_out_ready <= !hold && ($urandom % 4 != 0);
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  // ======================================================
  // main sequence
  initial begin
    void'($urandom(32'h8293e8fe));
    {psel, penable, pwrite, run, exact, hold} = '0;
    paddr = '0;
    pwdata = '0;
    i_sys_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(12'h000, 32'h0, 32'hffff_ffff, 1'b0);
    rd(12'h010, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      cfg(t_m[i], t_r[i], t_s[i], t_b[i], i == 0);
      rd(12'h000, last, 32'hffff_ffff, 1'b0);
      rd(12'h00c, 32'(t_d[i]), 32'hffff_ffff, 1'b0);
      check({30'h0, bess, butt}, 32'(t_f[i]), "front");
      repeat (300) @(posedge i_clk);
    end
    for (int r = 0; r < 5; r++) begin
      cfg(2, r, 4, 16, 1'b0);
      rd(12'h000, last, 32'hffff_ffff, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, cw(x_m[i], x_r[i], x_s[i]));
      rd(12'h000, last, 32'hffff_ffff, 1'b0);
      rd(12'h004, 32'h80, 32'h80, 1'b0);
    end
    cfg(0, 2, 0, 14, 1'b0);
    hold <= 1'b1;
    repeat (80) @(posedge i_clk);
    rd(12'h004, 32'h20, 32'h20, 1'b0);
    hold <= 1'b0;
    cfg(0, 2, 0, 14, 1'b0);
    repeat (20) @(posedge i_clk);
    run <= 1'b0;
    repeat (40) @(posedge i_clk);
    rd(12'h004, 32'h0, 32'h60, 1'b0);
    complete_run();
  end
endmodule : aaf_top_bench
`default_nettype wire
